//--- shared/dcaau_consts.vh
`ifndef DCAAU_CONSTS_VH
`define DCAAU_CONSTS_VH

// ----------------------------------------------------------------------
// Central ALU operation codes
// ----------------------------------------------------------------------
`define DCAAU_ALU_LOAD   4'h0
`define DCAAU_ALU_ADD    4'h1
`define DCAAU_ALU_ADDC   4'h2
`define DCAAU_ALU_SUB    4'h3
`define DCAAU_ALU_SUBB   4'h4
`define DCAAU_ALU_AND    4'h5
`define DCAAU_ALU_OR     4'h6
`define DCAAU_ALU_XOR    4'h7
`define DCAAU_ALU_SHL    4'h8
`define DCAAU_ALU_SHR    4'h9
`define DCAAU_ALU_ROL    4'ha
`define DCAAU_ALU_ROR    4'hb
`define DCAAU_ALU_CLRC   4'hc
`define DCAAU_ALU_SETC   4'hd

// ----------------------------------------------------------------------
// Product shift modes and shift counts
// ----------------------------------------------------------------------
`define DCAAU_PM_NONE    2'h0
`define DCAAU_PM_LEFT1   2'h1
`define DCAAU_PM_LEFT4   2'h2
`define DCAAU_PM_RIGHT6  2'h3
`define DCAAU_PSH_L1     1
`define DCAAU_PSH_L4     4
`define DCAAU_PSH_R6     6
`define DCAAU_ISH_MAX    5'h10

// ----------------------------------------------------------------------
// Address unit operation codes and compare modes
// ----------------------------------------------------------------------
`define DCAAU_AU_NOP     3'h0
`define DCAAU_AU_INC     3'h1
`define DCAAU_AU_DEC     3'h2
`define DCAAU_AU_ADDIDX  3'h3
`define DCAAU_AU_SUBIDX  3'h4
`define DCAAU_AU_LOAD    3'h5
`define DCAAU_AU_CMP     3'h6
`define DCAAU_CMP_EQ     2'h0
`define DCAAU_CMP_LT     2'h1
`define DCAAU_CMP_GT     2'h2
`define DCAAU_CMP_NE     2'h3
`define DCAAU_IDX_PTR    3'h0
`define DCAAU_PTR_STEP   16'h0001

// ----------------------------------------------------------------------
// Global space decode and reset values
// ----------------------------------------------------------------------
`define DCAAU_GLB_TOP    8'h80
`define DCAAU_RST_ACC    32'h0000_0000
`define DCAAU_RST_GLOBAL_SIZE_REG   8'h00
`define DCAAU_RST_IRQ    7'h00
`define DCAAU_RST_PTR    16'h0000
`define DCAAU_RST_SEL    3'h0

`endif

//--- core/dcaau_shift.v
`timescale 1ns/1ps
`default_nettype none
`include "dcaau_consts.vh"

// ----------------------------------------------------------------------
// Input and product scaling shifters
// ----------------------------------------------------------------------
module dcaau_shift (
    input  wire [15:0] din,
    input  wire [4:0]  ish,
    input  wire        sext,
    input  wire [31:0] prod,
    input  wire [1:0]  pm,
    output reg  [31:0] ish_out,
    output reg  [31:0] psh_out
);

    reg [31:0] ext;
    reg [4:0]  cnt;

    // Input shifter: 16-bit data moved 0 to 16 places left
    always @* begin
        ext     = {{16{sext & din[15]}}, din};
        cnt     = (ish > `DCAAU_ISH_MAX) ? `DCAAU_ISH_MAX : ish;
        ish_out = ext << cnt;
    end

    // Product shifter: left 0, 1, 4 or right 6 with sign kept
    always @* begin
        case (pm)
            `DCAAU_PM_NONE:  psh_out = prod;
            `DCAAU_PM_LEFT1: psh_out = prod << `DCAAU_PSH_L1;
            `DCAAU_PM_LEFT4: psh_out = prod << `DCAAU_PSH_L4;
            `DCAAU_PM_RIGHT6: psh_out = $signed(prod) >>> `DCAAU_PSH_R6;
            default:         psh_out = prod;
        endcase
    end

endmodule // dcaau_shift

`default_nettype wire

//--- core/dcaau_ptr_mem.v
`timescale 1ns/1ps
`default_nettype none

`include "dcaau_consts.vh"

// ----------------------------------------------------------------------
// Pointer register file, two registered read ports with write bypass
// ----------------------------------------------------------------------
module dcaau_ptr_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             we,
    input  wire [AW-1:0]    waddr,
    input  wire [WIDTH-1:0] wdata,
    input  wire [AW-1:0]    raddr_a,
    input  wire [AW-1:0]    raddr_b,
    output reg  [WIDTH-1:0] rdata_a,
    output reg  [WIDTH-1:0] rdata_b
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer i;

    // Read that sees a write landing on the same edge
    function [WIDTH-1:0] rd_byp;
        input [AW-1:0] ra;
        begin
            rd_byp = (we && (waddr == ra)) ? wdata : mem[ra];
        end
    endfunction

    // Storage and registered reads
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= `DCAAU_RST_PTR;
            end
            rdata_a <= `DCAAU_RST_PTR;
            rdata_b <= `DCAAU_RST_PTR;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata_a <= rd_byp(raddr_a);
            rdata_b <= rd_byp(raddr_b);
        end
    end

endmodule // dcaau_ptr_mem

`default_nettype wire

//--- core/dcaau_core.v
`timescale 1ns/1ps
`default_nettype none

`include "dcaau_consts.vh"

module dcaau_core #(
    parameter NPTR = 8,
    parameter NIRQ = 7
) (
    input  wire        CLK,
    input  wire        RST,
    // Central ALU
    input  wire        ALU_GO,
    input  wire [3:0]  ALU_OP,
    input  wire        ALU_SRC,
    input  wire [15:0] DIN,
    input  wire [4:0]  IN_SHIFT,
    input  wire        SIGN_EXT,
    input  wire [31:0] PROD,
    input  wire [1:0]  PROD_MODE,
    output reg  [31:0] RESULT,
    output reg         CARRY,
    output reg         ZERO,
    output reg         NEG,
    output reg         OVF,
    // Address unit
    input  wire        AU_GO,
    input  wire [2:0]  AU_SEL,
    input  wire [2:0]  AU_OP,
    input  wire [1:0]  AU_CMP,
    input  wire [15:0] AU_DATA,
    input  wire        AU_ACC,
    output reg  [15:0] DATA_ADDR,
    output reg  [2:0]  PTR_SELECT,
    output reg         CMP_TRUE,
    output reg         AU_DONE,
    output reg         BUSY,
    // Global space
    input  wire        GSIZE_WE,
    input  wire [7:0]  GSIZE_DATA,
    input  wire        READY,
    output reg  [7:0]  GLOBAL_SIZE,
    output reg         GLOBAL_STROBE,
    output reg         ACC_DONE,
    output reg         ACC_GLOBAL,
    // RAM map
    input  wire        MAP_SEL,
    output reg         DUAL_ACCESS_RAM_IN_DATA,
    output reg         DUAL_ACCESS_RAM_IN_PROG,
    // Interrupts
    input  wire [6:0]  IRQ_IN,
    input  wire [6:0]  IRQ_CLR,
    input  wire        IMASK_WE,
    input  wire [6:0]  IMASK_DATA,
    input  wire        INT_DISABLE,
    output reg  [6:0]  IRQ_FLAGS,
    output reg  [6:0]  IRQ_MASK,
    output reg         IRQ_REQ
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    wire [31:0] ish_out;
    wire [31:0] psh_out;
    wire [15:0] ptr_cur;
    wire [15:0] ptr_idx;
    reg  [31:0] opnd;
    reg  [32:0] wide;
    reg  [31:0] next_acc;
    reg         next_c;
    reg         next_ovf;
    reg         s1_valid;
    reg  [2:0]  s1_op;
    reg  [1:0]  s1_cmp;
    reg  [15:0] s1_data;
    reg         s1_acc;
    reg  [2:0]  s1_sel;
    reg  [15:0] next_ptr;
    reg         ptr_we;
    reg         next_cmp;
    reg  [6:0]  next_flags;
    wire        au_take;
    wire        glb_now;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Global decode: top bit always in the mask, so at most 32K words
    function glb_hit;
        input [15:0] addr;
        input [7:0]  size;
        reg   [7:0]  mask;
        begin
            mask    = size | `DCAAU_GLB_TOP;
            glb_hit = (size != `DCAAU_RST_GLOBAL_SIZE_REG) && ((addr[15:8] & mask) == mask);
        end
    endfunction

    // Signed overflow of a + b giving r
    function ovf_of;
        input a;
        input b;
        input r;
        begin
            ovf_of = (a == b) && (r != a);
        end
    endfunction

    // ------------------------------------------------------------------
    // Scaling shifters and pointer storage
    // ------------------------------------------------------------------
    dcaau_shift u_shift (
        .din     (DIN),
        .ish     (IN_SHIFT),
        .sext    (SIGN_EXT),
        .prod    (PROD),
        .pm      (PROD_MODE),
        .ish_out (ish_out),
        .psh_out (psh_out)
    );

    dcaau_ptr_mem #(
        .WIDTH (16),
        .DEPTH (NPTR),
        .AW    (3)
    ) u_ptr (
        .clk     (CLK),
        .rst     (RST),
        .we      (ptr_we),
        .waddr   (s1_sel),
        .wdata   (next_ptr),
        .raddr_a (AU_SEL),
        .raddr_b (`DCAAU_IDX_PTR),
        .rdata_a (ptr_cur),
        .rdata_b (ptr_idx)
    );

    // ------------------------------------------------------------------
    // Central ALU
    // ------------------------------------------------------------------

    // Operand from either shifter, other from the result register
    always @* begin
        opnd     = ALU_SRC ? psh_out : ish_out;
        wide     = {1'b0, RESULT};
        next_acc = RESULT;
        next_c   = CARRY;
        next_ovf = OVF;
        case (ALU_OP)
            `DCAAU_ALU_LOAD: begin
                next_acc = opnd;
            end
            `DCAAU_ALU_ADD, `DCAAU_ALU_ADDC: begin
                wide     = {1'b0, RESULT} + {1'b0, opnd}
                         + {32'h0000_0000, (ALU_OP == `DCAAU_ALU_ADDC) & CARRY};
                next_acc = wide[31:0];
                next_c   = wide[32];
                next_ovf = ovf_of(RESULT[31], opnd[31], wide[31]);
            end
            `DCAAU_ALU_SUB, `DCAAU_ALU_SUBB: begin
                // Carry set means no borrow
                wide     = {1'b0, RESULT} + {1'b0, ~opnd}
                         + {32'h0000_0000, (ALU_OP == `DCAAU_ALU_SUB) | CARRY};
                next_acc = wide[31:0];
                next_c   = wide[32];
                next_ovf = ovf_of(RESULT[31], ~opnd[31], wide[31]);
            end
            `DCAAU_ALU_AND: next_acc = RESULT & opnd;
            `DCAAU_ALU_OR:  next_acc = RESULT | opnd;
            `DCAAU_ALU_XOR: next_acc = RESULT ^ opnd;
            `DCAAU_ALU_SHL: begin
                next_acc = {RESULT[30:0], 1'b0};
                next_c   = RESULT[31];
            end
            `DCAAU_ALU_SHR: begin
                next_acc = {1'b0, RESULT[31:1]};
                next_c   = RESULT[0];
            end
            `DCAAU_ALU_ROL: begin
                next_acc = {RESULT[30:0], CARRY};
                next_c   = RESULT[31];
            end
            `DCAAU_ALU_ROR: begin
                next_acc = {CARRY, RESULT[31:1]};
                next_c   = RESULT[0];
            end
            `DCAAU_ALU_CLRC: next_c = 1'b0;
            `DCAAU_ALU_SETC: next_c = 1'b1;
            default: next_acc = RESULT;
        endcase
    end

    // Result register and status, updated on the edge the op is taken
    always @(posedge CLK) begin
        if (RST) begin
            RESULT <= `DCAAU_RST_ACC;
            CARRY  <= 1'b0;
            ZERO   <= 1'b1;
            NEG    <= 1'b0;
            OVF    <= 1'b0;
        end else if (ALU_GO) begin
            RESULT <= next_acc;
            CARRY  <= next_c;
            ZERO   <= (next_acc == `DCAAU_RST_ACC);
            NEG    <= next_acc[31];
            OVF    <= next_ovf;
        end
    end

    // ------------------------------------------------------------------
    // Address unit
    // ------------------------------------------------------------------
    assign au_take = AU_GO & ~BUSY;
    assign glb_now = glb_hit(ptr_cur, GLOBAL_SIZE);

    // Pointer update and compare against index pointer zero
    always @* begin
        next_ptr = ptr_cur;
        ptr_we   = 1'b0;
        next_cmp = CMP_TRUE;
        if (s1_valid) begin
            ptr_we = 1'b1;
            case (s1_op)
                `DCAAU_AU_INC:    next_ptr = ptr_cur + `DCAAU_PTR_STEP;
                `DCAAU_AU_DEC:    next_ptr = ptr_cur - `DCAAU_PTR_STEP;
                `DCAAU_AU_ADDIDX: next_ptr = ptr_cur + ptr_idx;
                `DCAAU_AU_SUBIDX: next_ptr = ptr_cur - ptr_idx;
                `DCAAU_AU_LOAD:   next_ptr = s1_data;
                `DCAAU_AU_CMP: begin
                    ptr_we = 1'b0;
                    case (s1_cmp)
                        `DCAAU_CMP_EQ: next_cmp = (ptr_cur == ptr_idx);
                        `DCAAU_CMP_LT: next_cmp = (ptr_cur < ptr_idx);
                        `DCAAU_CMP_GT: next_cmp = (ptr_cur > ptr_idx);
                        default:       next_cmp = (ptr_cur != ptr_idx);
                    endcase
                end
                default: ptr_we = 1'b0;
            endcase
        end
    end

    // Request stage: captured while the pointer file reads
    always @(posedge CLK) begin
        if (RST) begin
            s1_valid <= 1'b0;
            s1_op    <= `DCAAU_AU_NOP;
            s1_cmp   <= `DCAAU_CMP_EQ;
            s1_data  <= `DCAAU_RST_PTR;
            s1_acc   <= 1'b0;
            s1_sel   <= `DCAAU_RST_SEL;
        end else begin
            s1_valid <= au_take;
            if (au_take) begin
                s1_op   <= AU_OP;
                s1_cmp  <= AU_CMP;
                s1_data <= AU_DATA;
                s1_acc  <= AU_ACC;
                s1_sel  <= AU_SEL;
            end
        end
    end

    // Address outputs and data access sequencing
    always @(posedge CLK) begin
        if (RST) begin
            DATA_ADDR     <= `DCAAU_RST_PTR;
            PTR_SELECT    <= `DCAAU_RST_SEL;
            CMP_TRUE      <= 1'b0;
            AU_DONE       <= 1'b0;
            BUSY          <= 1'b0;
            GLOBAL_STROBE <= 1'b0;
            ACC_DONE      <= 1'b0;
            ACC_GLOBAL    <= 1'b0;
        end else begin
            AU_DONE  <= s1_valid;
            ACC_DONE <= 1'b0;
            CMP_TRUE <= next_cmp;
            if (s1_valid) begin
                DATA_ADDR  <= ptr_cur;
                PTR_SELECT <= s1_sel;
            end
            if (au_take && AU_ACC) begin
                BUSY <= 1'b1;
            end
            if (s1_valid && s1_acc) begin
                ACC_GLOBAL <= glb_now;
                if (glb_now) begin
                    GLOBAL_STROBE <= 1'b1;
                end else begin
                    ACC_DONE <= 1'b1;
                    BUSY     <= 1'b0;
                end
            end
            // Hold the strobe until memory answers
            if (GLOBAL_STROBE && READY) begin
                GLOBAL_STROBE <= 1'b0;
                ACC_DONE      <= 1'b1;
                BUSY          <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Global size register and RAM map
    // ------------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            GLOBAL_SIZE   <= `DCAAU_RST_GLOBAL_SIZE_REG;
            DUAL_ACCESS_RAM_IN_DATA <= 1'b1;
            DUAL_ACCESS_RAM_IN_PROG <= 1'b0;
        end else begin
            if (GSIZE_WE) begin
                GLOBAL_SIZE <= GSIZE_DATA;
            end
            DUAL_ACCESS_RAM_IN_DATA <= ~MAP_SEL;
            DUAL_ACCESS_RAM_IN_PROG <= MAP_SEL;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flags and masks
    // ------------------------------------------------------------------

    // Arriving request beats a clear in the same cycle
    always @* begin
        next_flags = (IRQ_FLAGS & ~IRQ_CLR) | IRQ_IN;
    end

    always @(posedge CLK) begin
        if (RST) begin
            IRQ_FLAGS <= `DCAAU_RST_IRQ;
            IRQ_MASK  <= `DCAAU_RST_IRQ;
            IRQ_REQ   <= 1'b0;
        end else begin
            IRQ_FLAGS <= next_flags;
            if (IMASK_WE) begin
                IRQ_MASK <= IMASK_DATA;
            end
            IRQ_REQ <= ~INT_DISABLE & (|(next_flags & IRQ_MASK));
        end
    end

endmodule // dcaau_core

`default_nettype wire

//--- test/dcaau_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------
// Global data memory answering the strobe
// ------
module dcaau_mem_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       strobe,
    input  wire logic [3:0] wait_cycles,
    input  wire logic       spurious,
    output var  logic       ready
);
    logic [3:0] cnt;

    // Ready after the set wait
    always @(negedge clk) begin
        if (rst) begin
            ready <= 1'b0;
            cnt   <= 4'h0;
        end else if (strobe && !ready && cnt == wait_cycles) begin
            ready <= 1'b1;
        end else if (strobe && !ready) begin
            cnt <= cnt + 4'h1;
        end else begin
            ready <= spurious & !strobe;
            cnt   <= 4'h0;
        end
    end
endmodule // dcaau_mem_model

`default_nettype wire

//--- test/dcaau_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcaau_consts.vh"

// ------
// Port checker
// ------
module dcaau_sva (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        ALU_GO,
    input wire logic [3:0]  ALU_OP,
    input wire logic [31:0] RESULT,
    input wire logic        CARRY,
    input wire logic        AU_GO,
    input wire logic        BUSY,
    input wire logic        AU_DONE,
    input wire logic [15:0] DATA_ADDR,
    input wire logic [7:0]  GLOBAL_SIZE,
    input wire logic        GLOBAL_STROBE,
    input wire logic        READY,
    input wire logic        ACC_DONE,
    input wire logic        MAP_SEL,
    input wire logic        DUAL_ACCESS_RAM_IN_DATA,
    input wire logic        DUAL_ACCESS_RAM_IN_PROG,
    input wire logic [6:0]  IRQ_IN,
    input wire logic [6:0]  IRQ_CLR,
    input wire logic [6:0]  IRQ_FLAGS,
    input wire logic [6:0]  IRQ_MASK,
    input wire logic        INT_DISABLE,
    input wire logic        IRQ_REQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Global window mask with the top bit forced
    wire [7:0] gmask = GLOBAL_SIZE | 8'h80;

    a_setc_cycle: assert property (ALU_GO && ALU_OP == `DCAAU_ALU_SETC |=> CARRY)
        else $error("setc carry");
    a_res_hold: assert property (!ALU_GO |=> $stable(RESULT))
        else $error("result moved");
    a_left_carry: assert property (ALU_GO && (ALU_OP == `DCAAU_ALU_SHL || ALU_OP == `DCAAU_ALU_ROL)
        |=> CARRY == $past(RESULT[31])) else $error("left carry");
    a_right_carry: assert property (ALU_GO && (ALU_OP == `DCAAU_ALU_SHR || ALU_OP == `DCAAU_ALU_ROR)
        |=> CARRY == $past(RESULT[0])) else $error("right carry");
    a_flag_latch: assert property (1'b1 |=> IRQ_FLAGS == (($past(IRQ_FLAGS) & ~$past(IRQ_CLR)) | $past(IRQ_IN)))
        else $error("irq flags");
    a_req_gate: assert property (1'b1 |=> IRQ_REQ == (!$past(INT_DISABLE) && (|(IRQ_FLAGS & $past(IRQ_MASK)))))
        else $error("irq request");
    a_map_follow: assert property (1'b1 |=> DUAL_ACCESS_RAM_IN_PROG == $past(MAP_SEL) && DUAL_ACCESS_RAM_IN_DATA == !$past(MAP_SEL))
        else $error("ram map");
    a_strobe_wait: assert property (GLOBAL_STROBE && !READY |=> GLOBAL_STROBE)
        else $error("strobe dropped");
    a_strobe_end: assert property (GLOBAL_STROBE && READY |=> !GLOBAL_STROBE && ACC_DONE)
        else $error("access not ended");
    a_au_latency: assert property (AU_GO && !BUSY |-> ##2 AU_DONE)
        else $error("au latency");
    a_glob_range: assert property ($rose(GLOBAL_STROBE) |-> GLOBAL_SIZE != 8'h00 && (DATA_ADDR[15:8] & gmask) == gmask)
        else $error("strobe range");

    c_glob_done: cover property (GLOBAL_STROBE && READY);
    c_irq_req: cover property (IRQ_REQ);
    c_addc: cover property (ALU_GO && ALU_OP == `DCAAU_ALU_ADDC);
endmodule // dcaau_sva

bind dcaau_core dcaau_sva i_sva (.*);

`default_nettype wire

//--- test/dsp_core_arith_addr_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcaau_consts.vh"

module dsp_core_arith_addr_unit_tb_top;
    logic        clk, rst, alu_go, alu_src, sext, au_go, au_acc, gsize_we, map_sel;
    logic        imask_we, int_dis, spur, carry, zero, neg, ovf, cmp_true, au_done, busy;
    logic        ready, gstrobe, acc_done, acc_global, in_data, in_prog, irq_req;
    logic [3:0]  alu_op, mwait;
    logic [15:0] din, au_data, data_addr;
    logic [4:0]  in_shift;
    logic [31:0] prod, result;
    logic [1:0]  pmode, au_cmp;
    logic [2:0]  au_sel, au_op, ptr_select;
    logic [7:0]  gsize_data, global_size;
    logic [6:0]  irq_in, irq_clr, imask_data, irq_flags, irq_mask;
    int          n_fail, comparisons;
    // ------
    // Expected tables
    // ------
    logic [3:0]  t_op [0:18] = '{4'h0, 4'h0, 4'h5, 4'h6, 4'h7, 4'h3, 4'h3, 4'h4, 4'h1, 4'h2,
        4'h0, 4'hc, 4'h8, 4'h0, 4'h9, 4'h0, 4'hd, 4'ha, 4'hb};
    logic [15:0] t_din [0:18] = '{16'h8000, 16'hff, 16'hff0, 16'h1, 16'hf00, 16'h1, 16'h2,
        16'h0, 16'h3, 16'h0, 16'h8000, 16'h0, 16'h0, 16'h1, 16'h0, 16'h8000, 16'h0, 16'h0, 16'h0};
    logic [4:0]  t_sh [0:18] = '{5'h4, 5'h8, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0,
        5'h10, 5'h0, 5'h0, 5'h0, 5'h0, 5'h10, 5'h0, 5'h0, 5'h0};
    logic [31:0] t_res [0:18] = '{32'hfff80000, 32'hff00, 32'hf00, 32'hf01, 32'h1, 32'h0,
        32'hfffffffe, 32'hfffffffd, 32'h0, 32'h1, 32'h80000000, 32'h80000000, 32'h0, 32'h1,
        32'h0, 32'h80000000, 32'h80000000, 32'h1, 32'h80000000};
    logic [18:0] t_ck = 19'h75be0; // Carry checked
    logic [18:0] t_cv = 19'h751a0; // Carry expected
    logic [31:0] t_prd [0:3] = '{32'hffffff00, 32'hfffffe00, 32'hfffff000, 32'hfffffffc};
    logic [2:0]  a_op [0:3] = '{3'h3, 3'h4, 3'h2, 3'h1};
    logic [15:0] a_exp [0:3] = '{16'h0104, 16'h0108, 16'h0104, 16'h0103};
    logic [7:0]  g_sz [0:5] = '{8'h00, 8'hf0, 8'hf0, 8'h01, 8'h01, 8'hff};
    logic [15:0] g_adr [0:5] = '{16'hff00, 16'hf000, 16'he000, 16'h8100, 16'h0100, 16'hffff};
    logic        g_exp [0:5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    dcaau_core i_dut (
        .CLK(clk), .RST(rst), .ALU_GO(alu_go), .ALU_OP(alu_op), .ALU_SRC(alu_src), .DIN(din),
        .IN_SHIFT(in_shift), .SIGN_EXT(sext), .PROD(prod), .PROD_MODE(pmode),
        .RESULT(result), .CARRY(carry), .ZERO(zero), .NEG(neg), .OVF(ovf), .AU_GO(au_go),
        .AU_SEL(au_sel), .AU_OP(au_op), .AU_CMP(au_cmp), .AU_DATA(au_data), .AU_ACC(au_acc),
        .DATA_ADDR(data_addr), .PTR_SELECT(ptr_select), .CMP_TRUE(cmp_true),
        .AU_DONE(au_done), .BUSY(busy), .GSIZE_WE(gsize_we), .GSIZE_DATA(gsize_data),
        .READY(ready), .GLOBAL_SIZE(global_size), .GLOBAL_STROBE(gstrobe),
        .ACC_DONE(acc_done), .ACC_GLOBAL(acc_global), .MAP_SEL(map_sel),
        .DUAL_ACCESS_RAM_IN_DATA(in_data), .DUAL_ACCESS_RAM_IN_PROG(in_prog), .IRQ_IN(irq_in), .IRQ_CLR(irq_clr),
        .IMASK_WE(imask_we), .IMASK_DATA(imask_data), .INT_DISABLE(int_dis),
        .IRQ_FLAGS(irq_flags), .IRQ_MASK(irq_mask), .IRQ_REQ(irq_req)
    );

    dcaau_mem_model i_mem (
        .clk(clk), .rst(rst), .strobe(gstrobe), .wait_cycles(mwait), .spurious(spur),
        .ready(ready)
    );

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ------
    // Access tasks
    // ------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic alu(input logic [3:0] op, input logic src, input logic [15:0] d,
                       input logic [4:0] sh, input logic sx);
        @(negedge clk);
        alu_go = 1'b1;
        alu_op = op;
        alu_src = src;
        din = d;
        in_shift = sh;
        sext = sx;
        @(negedge clk);
        alu_go = 1'b0;
    endtask

    task automatic au(input logic [2:0] s, input logic [2:0] op, input logic [15:0] d,
                      input logic acc);
        @(negedge clk);
        au_go = 1'b1;
        au_sel = s;
        au_op = op;
        au_data = d;
        au_acc = acc;
        @(negedge clk);
        au_go = 1'b0;
        for (int k = 0; k < 4 && au_done !== 1'b1; k++) @(negedge clk);
        chk("au done", 32'h1, au_done);
    endtask

    task automatic wacc;
        for (int k = 0; k < 40 && busy !== 1'b0; k++) @(negedge clk);
        chk("busy", 32'h0, busy);
        chk("acc done", 32'h1, acc_done);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------
    // Test sequence
    // ------
    initial begin
        {alu_go, alu_src, sext, au_go, au_acc, gsize_we, map_sel, imask_we, int_dis} = '0;
        {spur, alu_op, mwait, din, au_data, in_shift, prod, pmode, au_cmp} = '0;
        {au_sel, au_op, gsize_data, irq_in, irq_clr, imask_data} = '0;
        n_fail = 0;
        comparisons = 0;
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk("result", 32'h0, result);
        chk("ram map", 32'h2, {in_data, in_prog});
        $display("test reset done");
        for (int k = 0; k < 19; k++) begin
            alu(t_op[k], 1'b0, t_din[k], t_sh[k], k == 0);
            chk("result", t_res[k], result);
            chk("zero", t_res[k] == 32'h0, zero);
            chk("neg", t_res[k][31], neg);
            if (t_ck[k]) chk("carry", t_cv[k], carry);
        end
        chk("ovf", 32'h0, ovf);
        prod = 32'hffffff00;
        for (int k = 0; k < 4; k++) begin
            pmode = k[1:0];
            alu(4'h0, 1'b1, 16'h0000, 5'h00, 1'b0);
            chk("product", t_prd[k], result);
        end
        $display("test alu done");
        for (int k = 0; k < 8; k++) au(k[2:0], 3'h5, 16'h0100 + k[15:0], 1'b0);
        for (int k = 1; k < 8; k++) begin
            au(k[2:0], 3'h1, 16'h0000, 1'b0);
            chk("addr", 16'h0100 + k[15:0], data_addr);
        end
        au(3'h0, 3'h5, 16'h0004, 1'b0);
        for (int k = 0; k < 4; k++) begin
            au(3'h3, a_op[k], 16'h0000, 1'b0);
            chk("addr", a_exp[k], data_addr);
        end
        chk("select", 32'h3, ptr_select);
        for (int k = 0; k < 4; k++) begin
            au_cmp = k[1:0];
            au(3'h3, 3'h6, 16'h0000, 1'b0);
            chk("compare", k[1], cmp_true);
        end
        au(3'h7, 3'h5, 16'hffff, 1'b0);
        au(3'h7, 3'h1, 16'h0000, 1'b0);
        au(3'h7, 3'h1, 16'h0000, 1'b0);
        chk("wrap", 32'h0, data_addr);
        $display("test address done");
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            gsize_we = 1'b1;
            gsize_data = g_sz[k];
            @(negedge clk);
            gsize_we = 1'b0;
            chk("size", g_sz[k], global_size);
            mwait = k[3:0];
            au(3'h6, 3'h5, g_adr[k], 1'b0);
            au(3'h6, 3'h0, 16'h0000, 1'b1);
            wacc;
            chk("global", g_exp[k], acc_global);
        end
        mwait = 4'h8;
        au(3'h5, 3'h5, 16'h0050, 1'b0);
        au(3'h6, 3'h0, 16'h0000, 1'b1);
        @(negedge clk);
        au_go = 1'b1;
        au_sel = 3'h5;
        au_op = 3'h1;
        @(negedge clk);
        au_go = 1'b0;
        wacc;
        au(3'h5, 3'h1, 16'h0000, 1'b0);
        chk("refused", 32'h50, data_addr);
        spur = 1'b1;
        repeat (5) @(negedge clk);
        chk("strobe", 32'h0, gstrobe);
        spur = 1'b0;
        $display("test global done");
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            map_sel = ~k[0];
            @(negedge clk);
            chk("ram map", {k[0], ~k[0]}, {in_data, in_prog});
        end
        @(negedge clk);
        imask_we = 1'b1;
        imask_data = 7'h55;
        @(negedge clk);
        imask_we = 1'b0;
        chk("mask", 32'h55, irq_mask);
        for (int k = 0; k < 8; k++) begin
            int_dis = (k == 7);
            irq_in = 7'h01 << (k % 7);
            @(negedge clk);
            irq_in = 7'h00;
            irq_clr = 7'h7f;
            chk("flags", 7'h01 << (k % 7), irq_flags);
            chk("request", (k < 7) && !k[0], irq_req);
            @(negedge clk);
            irq_clr = 7'h00;
            chk("cleared", 32'h0, irq_flags);
        end
        int_dis = 1'b0;
        $display("test interrupt done");
        wrap_up;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        wrap_up;
    end
endmodule // dsp_core_arith_addr_unit_tb_top

`default_nettype wire
